// File: test/icu_checker.sv
`timescale 1ns/1ps
module icu_checker #(parameter PC_W = 13) (
   input wire            MCLK_I,
   input wire            SRST_I,
   input wire            RETFI_EXEC_I,
   input wire            PSEL,
   input wire            PENABLE,
   input wire            PREADY,
   input wire            PSLVERR,
   input wire [31:0]     PRDATA,
   input wire            VEC_LOAD_O,
   input wire [PC_W-1:0] VEC_PC_O,
   input wire            RET_VALID_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SRST_I);
   property p_rdy; PREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state");
   property p_err; PSLVERR |-> PSEL && PENABLE; endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_hi; PRDATA[31:8] == 24'h00_0000; endproperty
   a_hi: assert property (p_hi) else $error("upper bits");
   property p_vec; VEC_LOAD_O |=> VEC_PC_O == 13'h0004; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_gap; VEC_LOAD_O |=> !VEC_LOAD_O [*8]; endproperty
   a_gap: assert property (p_gap) else $error("reentry");
   property p_rst; $fell(SRST_I) |-> !VEC_LOAD_O [*8]; endproperty
   a_rst: assert property (p_rst) else $error("entry at reset");
   property p_ret; RET_VALID_O |=> !RET_VALID_O; endproperty
   a_ret: assert property (p_ret) else $error("long return");
   property p_cause;
      RET_VALID_O |-> $past(RETFI_EXEC_I) || $past(RETFI_EXEC_I, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("stray pop");
endmodule

bind icu_top icu_checker #(.PC_W(PC_W)) icu_checker_inst (
   .MCLK_I(MCLK_I), .SRST_I(SRST_I), .RETFI_EXEC_I(RETFI_EXEC_I),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PRDATA(PRDATA), .VEC_LOAD_O(VEC_LOAD_O), .VEC_PC_O(VEC_PC_O),
   .RET_VALID_O(RET_VALID_O));

// File: test/icu_core_model.sv
`timescale 1ns/1ps
module icu_core_model #(parameter PC_W = 13) (
   input  wire            clk_i,
   input  wire            rst_i,
   input  wire            vec_load_i,
   input  wire [PC_W-1:0] vec_pc_i,
   input  wire            ret_valid_i,
   input  wire [PC_W-1:0] ret_pc_i,
   output reg  [PC_W-1:0] pc_o
);
   // pc holds still between jumps, so the capture point is moot
   always @(posedge clk_i) begin
      if (rst_i)
         pc_o <= 13'h0123;
      else if (vec_load_i)
         pc_o <= vec_pc_i;
      else if (ret_valid_i)
         pc_o <= ret_pc_i;
   end
endmodule

// File: test/icu_top_bench.sv
`timescale 1ns/1ps
module icu_top_bench;
   logic        MCLK_I, SRST_I, POR_I, PSEL, PENABLE, PWRITE, RETFI_EXEC_I;
   logic [31:0] PADDR, PWDATA, rd;
   logic [3:0]  ev;
   logic        er;
   wire         PREADY, PSLVERR, VEC_LOAD_O, RET_VALID_O, IRQ_O, nop;
   wire  [31:0] PRDATA;
   wire  [12:0] VEC_PC_O, RET_PC_O, pc;
   int          n, err_count = 0, checks_done = 0;
   icu_top icu_top_inst (
      .MCLK_I(MCLK_I), .SRST_I(SRST_I), .POR_I(POR_I),
      .EXT_EDGE_I(ev[0]), .TMR_OVF_I(ev[1]), .PORT_CHG_I(ev[2]),
      .CMP_EVT_I(ev[3]), .RETFI_EXEC_I(RETFI_EXEC_I),
      .CUR_PC_VALID_I(1'b1), .CUR_PC_I(pc), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PRDATA(PRDATA), .VEC_LOAD_O(VEC_LOAD_O), .VEC_PC_O(VEC_PC_O),
      .FORCE_NOP_O(nop), .RET_PC_O(RET_PC_O), .RET_VALID_O(RET_VALID_O),
      .IRQ_O(IRQ_O));
   icu_core_model icu_core_model_inst (
      .clk_i(MCLK_I), .rst_i(SRST_I), .vec_load_i(VEC_LOAD_O),
      .vec_pc_i(VEC_PC_O), .ret_valid_i(RET_VALID_O),
      .ret_pc_i(RET_PC_O), .pc_o(pc));
   initial begin
      MCLK_I = 1'b0;
      forever #10 MCLK_I = ~MCLK_I;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK_I);
      PENABLE <= 1'b1;
      do @(posedge MCLK_I); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK_I);
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask
   task pulse(input logic [3:0] m);
      ev <= m;
      @(posedge MCLK_I);
      ev <= 4'h0;
      @(posedge MCLK_I);
   endtask
   task wvec;
      n = 0;
      while (VEC_LOAD_O !== 1'b1 && n < 40) begin
         @(posedge MCLK_I);
         n++;
      end
   endtask
   task rst(input logic p);
      POR_I <= p;
      SRST_I <= 1'b1;
      repeat (12) @(posedge MCLK_I);
      SRST_I <= 1'b0;
      @(posedge MCLK_I);
   endtask
   task t_flags;
      rdc(32'h0000_002C, 32'h0000_0000);
      rdc(32'h0000_0230, 32'h0000_0000);
      apb(1'b0, 32'h0000_0100, 32'h0000_0000);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
      pulse(4'hF);
      rdc(32'h0000_002C, 32'h0000_0007);
      rdc(32'h0000_0030, 32'h0000_0040);
      chk(IRQ_O, 1'b0);
      apb(1'b1, 32'h0000_03C4, 32'h0000_0002);
      chk(IRQ_O, 1'b1);
      apb(1'b1, 32'h0000_03C0, 32'h0000_000F);
      chk(IRQ_O, 1'b0);
      rst(1'b0);
      rdc(32'h0000_002C, 32'h0000_0001);
      rdc(32'h0000_0030, 32'h0000_0000);
      $display("flags done");
   endtask
   task t_entry;
      apb(1'b1, 32'h0000_002C, 32'h0000_0090);
      pulse(4'h1);
      wvec;
      chk(n >= 11 && n <= 17, 1'b1);
      @(posedge MCLK_I);
      chk(pc, 13'h0004);
      rdc(32'h0000_002C, 32'h0000_0012);
      apb(1'b1, 32'h0000_002C, 32'h0000_0010);
      RETFI_EXEC_I <= 1'b1;
      @(posedge MCLK_I);
      RETFI_EXEC_I <= 1'b0;
      repeat (4) if (RET_VALID_O !== 1'b1) @(posedge MCLK_I);
      chk(RET_PC_O, 13'h0123);
      rdc(32'h0000_002C, 32'h0000_0090);
      chk(pc, 13'h0123);
      wvec;
      chk(n, 40);
      $display("entry done");
   endtask
   task t_cmp;
      apb(1'b1, 32'h0000_0230, 32'h0000_0040);
      apb(1'b1, 32'h0000_002C, 32'h0000_0080);
      pulse(4'h8);
      wvec;
      chk(n, 40);
      apb(1'b1, 32'h0000_002C, 32'h0000_00C0);
      wvec;
      chk(n < 40, 1'b1);
      $display("cmp done");
   endtask
   task t_nop;
      apb(1'b1, 32'h0000_002C, 32'h0000_0080);
      apb(1'b1, 32'h0000_002C, 32'h0000_0000);
      n = 0;
      repeat (10) begin
         @(posedge MCLK_I);
         if (nop === 1'b1) n++;
      end
      chk(n, 4);
      apb(1'b1, 32'h0000_002C, 32'h0000_00C0);
      wvec;
      chk(n < 40, 1'b1);
      $display("nop done");
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {PSEL, PENABLE, PWRITE, RETFI_EXEC_I, ev, PADDR, PWDATA} = '0;
      rst(1'b1);
      t_flags;
      t_entry;
      t_cmp;
      t_nop;
      final_report;
   end
   initial begin
      repeat (5000) @(posedge MCLK_I);
      err_count++;
      final_report;
   end
endmodule

// File: verilog/icu_cycle_gen.v
`timescale 1ns/1ps
`include "icu_defs.vh"
// instruction-cycle strobe: one pulse every four clocks
module icu_cycle_gen #(
   parameter OSC_PER_CYC = `ICU_OSC_PER_CYC
) (
   input  wire MCLK_I,
   input  wire SRST_I,
   output reg  CYC_O
);
   reg [2:0] phase;

   always @(posedge MCLK_I) begin
      if (SRST_I) begin
         phase <= 3'h0;
         CYC_O <= 1'b0;
      end else begin
         if (phase == OSC_PER_CYC - 1) begin
            phase <= 3'h0;
            CYC_O <= 1'b1;
         end else begin
            phase <= phase + 3'h1;
            CYC_O <= 1'b0;
         end
      end
   end
endmodule

// File: verilog/icu_defs.vh
`ifndef ICU_DEFS_VH
`define ICU_DEFS_VH
// register word indices (printed offsets are indices)
`define ICU_IDX_CTRL      8'h0B
`define ICU_IDX_PFLAG     8'h0C
`define ICU_IDX_PEN       8'h8C
`define ICU_IDX_STAT      8'hF0
`define ICU_IDX_MASK      8'hF1
`define ICU_IDX_CORE      8'hF2
`define ICU_ADDR_W        10
// control register fields, and the compare bit of the peripheral flag and enable registers
`define ICU_GIE_BIT       7
`define ICU_PERIPHERAL_IRQ_ENABLE_BIT      6
`define ICU_TIMER_OVERFLOW_IRQ_ENABLE_BIT      5
`define ICU_EXT_PIN_IRQ_ENABLE_BIT      4
`define ICU_PORT_CHANGE_IRQ_ENABLE_BIT      3
`define ICU_TIMER_OVERFLOW_FLAG_BIT      2
`define ICU_EXT_PIN_FLAG_BIT      1
`define ICU_PORT_CHANGE_FLAG_BIT      0
`define ICU_CMP_BIT       6
`define ICU_CTRL_RST      8'h00
`define ICU_PFLAG_MASK    8'h40
// vector, timing and sizes
`define ICU_VECTOR        13'h0004
`define ICU_PC_W          13
`define ICU_OSC_PER_CYC   4
`define ICU_SRC_COUNT     4
`define ICU_STACK_DEPTH   8
`endif

// File: verilog/icu_top.v
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "icu_defs.vh"

module icu_top #(
   parameter PC_W        = `ICU_PC_W,
   parameter STACK_DEPTH = `ICU_STACK_DEPTH
) (
   input  wire              MCLK_I,
   input  wire              SRST_I,
   input  wire              POR_I,
   input  wire              EXT_EDGE_I,
   input  wire              TMR_OVF_I,
   input  wire              PORT_CHG_I,
   input  wire              CMP_EVT_I,
   input  wire              RETFI_EXEC_I,
   input  wire              CUR_PC_VALID_I,
   input  wire [PC_W-1:0]   CUR_PC_I,
   input  wire              PSEL,
   input  wire              PENABLE,
   input  wire              PWRITE,
   input  wire [31:0]       PADDR,
   input  wire [31:0]       PWDATA,
   output wire              PREADY,
   output wire              PSLVERR,
   output reg  [31:0]       PRDATA,
   output reg               VEC_LOAD_O,
   output reg  [PC_W-1:0]   VEC_PC_O,
   output reg               FORCE_NOP_O,
   output reg  [PC_W-1:0]   RET_PC_O,
   output reg               RET_VALID_O,
   output wire              IRQ_O
);
   localparam ST_RUN = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_ENTRY = 2'd2;
   localparam [7:0] CTRL_RST = `ICU_CTRL_RST;

   wire              cyc;
   reg  [7:0]        intctl;
   reg               cmp_flag;
   reg               cmp_en;
   reg  [3:0]        stat;
   reg  [3:0]        mask;
   reg  [1:0]        state;
   reg  [1:0]        lat;
   reg               nop_pend;
   reg  [PC_W-1:0]   stack [0:STACK_DEPTH-1];
   reg  [2:0]        sp;
   reg  [7:0]        next_intctl;
   reg               next_cmp_flag;
   reg  [3:0]        next_stat;
   wire              wr_acc;
   wire              rd_acc;
   wire              req;
   wire [3:0]        evt;
   integer           i;

   function addr_hit;
      input [31:0] a;
      input [7:0]  ix;
      begin
         addr_hit = (a[31:`ICU_ADDR_W] == 0) && (a[1:0] == 2'b00)
                    && (a[9:2] == ix);
      end
   endfunction

   icu_cycle_gen #(
      .OSC_PER_CYC (`ICU_OSC_PER_CYC)
   ) u_cyc (
      .MCLK_I (MCLK_I),
      .SRST_I (SRST_I),
      .CYC_O  (cyc)
   );

   assign PREADY  = 1'b1;
   assign wr_acc  = PSEL & PENABLE & PWRITE;
   assign rd_acc  = PSEL & PENABLE & ~PWRITE;
   assign PSLVERR = PSEL & PENABLE & ~(addr_hit(PADDR, `ICU_IDX_CTRL) |
                    addr_hit(PADDR, `ICU_IDX_PFLAG) |
                    addr_hit(PADDR, `ICU_IDX_PEN) |
                    addr_hit(PADDR, `ICU_IDX_STAT) |
                    addr_hit(PADDR, `ICU_IDX_MASK) |
                    addr_hit(PADDR, `ICU_IDX_CORE));

   // four request sources, unmasked requests
   assign req = intctl[`ICU_GIE_BIT] & (
      (intctl[`ICU_TIMER_OVERFLOW_IRQ_ENABLE_BIT] & intctl[`ICU_TIMER_OVERFLOW_FLAG_BIT]) |
      (intctl[`ICU_EXT_PIN_IRQ_ENABLE_BIT] & intctl[`ICU_EXT_PIN_FLAG_BIT]) |
      (intctl[`ICU_PORT_CHANGE_IRQ_ENABLE_BIT] & intctl[`ICU_PORT_CHANGE_FLAG_BIT]) |
      (intctl[`ICU_PERIPHERAL_IRQ_ENABLE_BIT] & cmp_en & cmp_flag));

   assign evt = {CMP_EVT_I, PORT_CHG_I, EXT_EDGE_I, TMR_OVF_I};
   assign IRQ_O = |(stat & mask);

   always @* begin
      next_intctl = intctl;
      next_cmp_flag = cmp_flag;
      if (wr_acc && addr_hit(PADDR, `ICU_IDX_CTRL))
         next_intctl = PWDATA[7:0];
      if (wr_acc && addr_hit(PADDR, `ICU_IDX_PFLAG))
         next_cmp_flag = PWDATA[`ICU_CMP_BIT];
      // entry clears enable, return sets it
      if (state == ST_ENTRY && cyc)
         next_intctl[`ICU_GIE_BIT] = 1'b0;
      else if (RETFI_EXEC_I)
         next_intctl[`ICU_GIE_BIT] = 1'b1;
      // events set regardless of enables, set beats clear
      if (TMR_OVF_I)
         next_intctl[`ICU_TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
      if (EXT_EDGE_I)
         next_intctl[`ICU_EXT_PIN_FLAG_BIT] = 1'b1;
      if (PORT_CHG_I)
         next_intctl[`ICU_PORT_CHANGE_FLAG_BIT] = 1'b1;
      if (CMP_EVT_I)
         next_cmp_flag = 1'b1;
      next_stat = stat;
      if (wr_acc && addr_hit(PADDR, `ICU_IDX_STAT))
         next_stat = stat & ~PWDATA[3:0];
      next_stat = next_stat | evt;
   end

   always @(posedge MCLK_I) begin
      if (SRST_I) begin
         // port-change flag kept on non-power-on reset
         intctl   <= {CTRL_RST[7:1],
                      POR_I ? 1'b0 : intctl[`ICU_PORT_CHANGE_FLAG_BIT]};
         cmp_flag <= 1'b0;
         cmp_en   <= 1'b0;
         stat     <= 4'h0;
         mask     <= 4'h0;
         state    <= ST_RUN;
         lat      <= 2'd0;
         nop_pend <= 1'b0;
         sp       <= 3'd0;
         VEC_LOAD_O  <= 1'b0;
         VEC_PC_O    <= {PC_W{1'b0}};
         FORCE_NOP_O <= 1'b0;
         RET_PC_O    <= {PC_W{1'b0}};
         RET_VALID_O <= 1'b0;
         for (i = 0; i < STACK_DEPTH; i = i + 1)
            stack[i] <= {PC_W{1'b0}};
      end else begin
         intctl   <= next_intctl;
         cmp_flag <= next_cmp_flag;
         stat     <= next_stat;
         VEC_LOAD_O  <= 1'b0;
         RET_VALID_O <= 1'b0;
         if (wr_acc && addr_hit(PADDR, `ICU_IDX_PEN))
            cmp_en <= PWDATA[`ICU_CMP_BIT];
         if (wr_acc && addr_hit(PADDR, `ICU_IDX_MASK))
            mask <= PWDATA[3:0];
         // software clearing enable: nop next cycle
         if (wr_acc && addr_hit(PADDR, `ICU_IDX_CTRL) &&
             intctl[`ICU_GIE_BIT] && !PWDATA[`ICU_GIE_BIT])
            nop_pend <= 1'b1;
         else if (cyc)
            nop_pend <= 1'b0;
         if (cyc)
            FORCE_NOP_O <= nop_pend;
         if (RETFI_EXEC_I && sp != 3'd0) begin
            RET_PC_O    <= stack[sp - 3'd1];
            RET_VALID_O <= 1'b1;
            sp          <= sp - 3'd1;
         end
         case (state)
            ST_RUN: begin
               if (cyc && req && !nop_pend) begin
                  state <= ST_WAIT;
                  lat   <= 2'd0;
               end
            end
            ST_WAIT: begin
               // fixed latency, independent of instruction length
               if (cyc) begin
                  if (lat == 2'd1)
                     state <= ST_ENTRY;
                  lat <= lat + 2'd1;
               end
            end
            ST_ENTRY: begin
               if (cyc) begin
                  // only the return PC is saved
                  stack[sp]  <= CUR_PC_I;
                  sp         <= sp + 3'd1;
                  VEC_PC_O   <= `ICU_VECTOR;
                  VEC_LOAD_O <= 1'b1;
                  state      <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // software must clear flags before re-enabling
   always @(posedge MCLK_I) begin
      if (SRST_I)
         PRDATA <= 32'h0000_0000;
      else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= 32'h0000_0000;
         if (addr_hit(PADDR, `ICU_IDX_CTRL))
            PRDATA[7:0] <= intctl;
         else if (addr_hit(PADDR, `ICU_IDX_PFLAG))
            PRDATA[`ICU_CMP_BIT] <= cmp_flag;
         else if (addr_hit(PADDR, `ICU_IDX_PEN))
            PRDATA[`ICU_CMP_BIT] <= cmp_en;
         else if (addr_hit(PADDR, `ICU_IDX_STAT))
            PRDATA[3:0] <= stat;
         else if (addr_hit(PADDR, `ICU_IDX_MASK))
            PRDATA[3:0] <= mask;
         else if (addr_hit(PADDR, `ICU_IDX_CORE))
            PRDATA[2:0] <= sp;
      end
   end
endmodule
